// *** hdl/dac_ctrl_params.svh ***
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH
// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_RW_BIT 23
`define FRAME_ADDR_HI 22
`define FRAME_ADDR_LO 20
`define FRAME_DATA_HI 19
// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define ADDR_DAC 3'h1
`define ADDR_CTRL 3'h2
`define ADDR_CLEAR_VALUE 3'h3
`define ADDR_SW_STROBES 3'h4
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTRL_FEEDBACK_BIT 1
`define CTRL_CLAMP_BIT 2
`define CTRL_FLOAT_BIT 3
`define CTRL_TWOS_BIT 4
`define CTRL_LIN_LO 6
`define CTRL_LIN_HI 9
// ---------------------------------------------------------------
// software strobe fields
// ---------------------------------------------------------------
`define SW_LOAD_BIT 0
`define SW_CLEAR_BIT 1
`define SW_RESET_BIT 2
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CTRL_RST 20'h0000C
`define CLEAR_VALUE_RST 20'h00000
`define DAC_RST 20'h00000
`define READ_FLAG 1'h1
`endif

// *** hdl/dac_ctrl_pkg.sv ***
// ---------------------------------------------------------------
// shared types
// ---------------------------------------------------------------
package dac_ctrl_pkg;
  // state of the analogue output stage
  typedef enum logic [1:0] {
    OUT_NORMAL,
    OUT_FLOAT,
    OUT_CLAMP
  } out_state_t;
endpackage : dac_ctrl_pkg

// *** hdl/dac_output_state_control.sv ***
`include "dac_ctrl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module dac_output_state_control #(
  parameter int DATA_W = 20
) (
  input wire logic core_clk, // core clock, 20 MHz
  input wire logic rstn, // power-on reset, active low
  input wire logic sclk, // serial link clock
  input wire logic sync_n, // frame select, active low
  input wire logic sdin, // serial data in
  output logic sdo, // serial readback out
  input wire logic load_strobe_n, // load pin, active low
  input wire logic clear_strobe_n, // clear pin, active low
  output logic [DATA_W-1:0] dac_code, // straight binary core code
  output logic ref_disconnect, // references disconnected
  output logic output_clamp, // output clamped to ground
  output var dac_ctrl_pkg::out_state_t out_state, // decoded state
  output logic [3:0] lin_comp, // linearity trim
  output logic feedback_resistor_select // feedback resistor select
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (DATA_W != `FRAME_DATA_HI + 1) begin : g_bad_width
    $error("DATA_W must equal the frame data width");
  end

  // output state decode of the control word
  function automatic dac_ctrl_pkg::out_state_t decode_state(
    input logic [DATA_W-1:0] c
  );
    if (c[`CTRL_CLAMP_BIT]) begin
      return dac_ctrl_pkg::OUT_CLAMP;
    end else if (c[`CTRL_FLOAT_BIT]) begin
      return dac_ctrl_pkg::OUT_FLOAT;
    end
    return dac_ctrl_pkg::OUT_NORMAL;
  endfunction : decode_state

  // convert register contents to straight binary code
  function automatic logic [DATA_W-1:0] to_code(
    input logic [DATA_W-1:0] v,
    input logic twos
  );
    return twos ? {~v[DATA_W-1], v[DATA_W-2:0]} : v;
  endfunction : to_code

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [`FRAME_BITS-1:0] shift_in;
  logic [`FRAME_BITS-1:0] shift_out;
  logic [`FRAME_BITS-1:0] frame_word;
  logic frame_tog;
  logic [`FRAME_BITS-1:0] readback;
  logic [`FRAME_BITS-1:0] next_shift_in;
  assign next_shift_in = {shift_in[`FRAME_BITS-2:0], sdin};

  // bit counter, restarted whenever the frame select is high
  always_ff @(posedge sclk or posedge sync_n or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 5'h00;
    end else if (sync_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != 5'(`FRAME_BITS)) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // input shifter, msb first
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      shift_in <= 24'h000000;
    end else if (!sync_n) begin
      shift_in <= next_shift_in;
    end
  end

  // complete frame captured and announced by toggle
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      frame_word <= 24'h000000;
      frame_tog <= 1'h0;
    end else if (!sync_n && bit_cnt == 5'(`FRAME_BITS - 1)) begin
      frame_word <= next_shift_in;
      frame_tog <= ~frame_tog;
    end
  end

  // readback shifter, loaded at frame start; readback is stable then
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      shift_out <= 24'h000000;
      sdo <= 1'h0;
    end else if (!sync_n) begin
      if (bit_cnt == 5'h00) begin
        sdo <= readback[`FRAME_BITS-1];
        shift_out <= {readback[`FRAME_BITS-2:0], 1'h0};
      end else begin
        sdo <= shift_out[`FRAME_BITS-1];
        shift_out <= {shift_out[`FRAME_BITS-2:0], 1'h0};
      end
    end
  end

  // ---------------------------------------------------------------
  // core domain: synchronisers
  // ---------------------------------------------------------------
  logic tog_s1, tog_s2, tog_s3;
  logic load_n_s1, load_n_s2, load_n_d;
  logic clear_n_s1, clear_n_s2, clear_n_d;

  // two-flop synchronisers plus edge history
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tog_s1 <= 1'h0;
      tog_s2 <= 1'h0;
      tog_s3 <= 1'h0;
      load_n_s1 <= 1'h1;
      load_n_s2 <= 1'h1;
      load_n_d <= 1'h1;
      clear_n_s1 <= 1'h1;
      clear_n_s2 <= 1'h1;
      clear_n_d <= 1'h1;
    end else begin
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      load_n_s1 <= load_strobe_n;
      load_n_s2 <= load_n_s1;
      load_n_d <= load_n_s2;
      clear_n_s1 <= clear_strobe_n;
      clear_n_s2 <= clear_n_s1;
      clear_n_d <= clear_n_s2;
    end
  end

  // ---------------------------------------------------------------
  // core domain: frame decode
  // ---------------------------------------------------------------
  logic frame_evt, wr, rd;
  logic [2:0] addr;
  logic [DATA_W-1:0] data;
  logic sw_wr, pin_load, pin_clear, sw_load, sw_clear, sw_reset;
  logic do_load, do_clear;

  // word is stable: it changes only at the end of the next frame
  assign frame_evt = tog_s2 ^ tog_s3;
  assign wr = frame_evt && !frame_word[`FRAME_RW_BIT];
  assign rd = frame_evt && frame_word[`FRAME_RW_BIT];
  assign addr = frame_word[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign data = frame_word[`FRAME_DATA_HI:0];
  assign sw_wr = wr && addr == `ADDR_SW_STROBES;

  // pin falling edges and their software twins
  assign pin_load = load_n_d && !load_n_s2;
  assign pin_clear = clear_n_d && !clear_n_s2;
  assign sw_load = sw_wr && data[`SW_LOAD_BIT] && clear_n_s2;
  assign sw_clear = sw_wr && data[`SW_CLEAR_BIT] && load_n_s2;
  assign sw_reset = sw_wr && data[`SW_RESET_BIT];
  assign do_load = pin_load || sw_load;
  assign do_clear = pin_clear || sw_clear;

  // ---------------------------------------------------------------
  // core domain: registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] input_reg, dac_reg, clear_value, ctrl;

  // pending value from dac address writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_reg <= `DAC_RST;
    end else if (sw_reset) begin
      input_reg <= `DAC_RST;
    end else if (wr && addr == `ADDR_DAC) begin
      input_reg <= data;
    end
  end

  // dac register; clear takes priority over load
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dac_reg <= `DAC_RST;
    end else if (sw_reset) begin
      dac_reg <= `DAC_RST;
    end else if (do_clear) begin
      dac_reg <= clear_value;
    end else if (do_load) begin
      dac_reg <= input_reg;
    end
  end

  // clear value register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clear_value <= `CLEAR_VALUE_RST;
    end else if (sw_reset) begin
      clear_value <= `CLEAR_VALUE_RST;
    end else if (wr && addr == `ADDR_CLEAR_VALUE) begin
      clear_value <= data;
    end
  end

  // control register: float and clamp set at power-on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RST;
    end else if (sw_reset) begin
      ctrl <= `CTRL_RST;
    end else if (wr && addr == `ADDR_CTRL) begin
      ctrl <= data;
    end
  end

  // readback for the next frame; strobe register reads back zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readback <= 24'h000000;
    end else if (rd) begin
      if (addr == `ADDR_DAC) begin
        readback <= {`READ_FLAG, addr, dac_reg};
      end else if (addr == `ADDR_CTRL) begin
        readback <= {`READ_FLAG, addr, ctrl};
      end else if (addr == `ADDR_CLEAR_VALUE) begin
        readback <= {`READ_FLAG, addr, clear_value};
      end else begin
        readback <= {`READ_FLAG, addr, 20'h00000};
      end
    end
  end

  // ---------------------------------------------------------------
  // core domain: outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dac_code <= 20'h00000;
      ref_disconnect <= 1'h1;
      output_clamp <= 1'h1;
      out_state <= dac_ctrl_pkg::OUT_CLAMP;
      lin_comp <= 4'h0;
      feedback_resistor_select <= 1'h0;
    end else begin
      dac_code <= to_code(dac_reg, ctrl[`CTRL_TWOS_BIT]);
      ref_disconnect <= ctrl[`CTRL_FLOAT_BIT];
      output_clamp <= ctrl[`CTRL_CLAMP_BIT];
      out_state <= decode_state(ctrl);
      lin_comp <= ctrl[`CTRL_LIN_HI:`CTRL_LIN_LO];
      feedback_resistor_select <= ctrl[`CTRL_FEEDBACK_BIT];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_sw_write;
    sw_wr && !data[`SW_RESET_BIT] && !pin_load && !pin_clear;
  endsequence
  property p_sw_clear;
    s_sw_write ##0 data[`SW_CLEAR_BIT] && load_n_s2
      |=> dac_reg == $past(clear_value) ##1
        dac_code == ($past(clear_value, 2) ^
          {ctrl[`CTRL_TWOS_BIT], {(DATA_W-1){1'h0}}});
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software clear did not copy clear value");
  property p_clear_blocked;
    s_sw_write ##0 data[`SW_CLEAR_BIT] && !load_n_s2 &&
      !data[`SW_LOAD_BIT] |=> $stable(dac_reg);
  endproperty
  a_clear_blocked: assert property (p_clear_blocked)
    else $error("clear acted while load pin low");
  property p_load_blocked;
    s_sw_write ##0 data[`SW_LOAD_BIT] && !clear_n_s2 &&
      !data[`SW_CLEAR_BIT] |=> $stable(dac_reg);
  endproperty
  a_load_blocked: assert property (p_load_blocked)
    else $error("load acted while clear pin low");
  property p_sw_load;
    s_sw_write ##0 data[`SW_LOAD_BIT] && clear_n_s2 &&
      !data[`SW_CLEAR_BIT] |=> dac_reg == $past(input_reg);
  endproperty
  a_sw_load: assert property (p_sw_load)
    else $error("software load did not transfer pending data");
  property p_soft_reset;
    sw_reset |=> ctrl == `CTRL_RST && dac_reg == `DAC_RST &&
      clear_value == `CLEAR_VALUE_RST ##1
      ref_disconnect && output_clamp && out_state == dac_ctrl_pkg::OUT_CLAMP;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("reset bit did not restore power-on state");
  property p_hold_state;
    !(wr && addr == `ADDR_CTRL) && !sw_reset |=> $stable(ctrl);
  endproperty
  a_hold_state: assert property (p_hold_state)
    else $error("control changed without a control write");
  property p_decode;
    ##1 output_clamp == $past(ctrl[`CTRL_CLAMP_BIT]) &&
      ref_disconnect == $past(ctrl[`CTRL_FLOAT_BIT]) &&
      out_state == ($past(ctrl[`CTRL_CLAMP_BIT]) ? dac_ctrl_pkg::OUT_CLAMP :
      $past(ctrl[`CTRL_FLOAT_BIT]) ? dac_ctrl_pkg::OUT_FLOAT :
      dac_ctrl_pkg::OUT_NORMAL);
  endproperty
  a_decode: assert property (p_decode)
    else $error("output state decode wrong");
  property p_coding;
    ##1 dac_code == ($past(dac_reg) ^
      {$past(ctrl[`CTRL_TWOS_BIT]), {(DATA_W-1){1'h0}}});
  endproperty
  a_coding: assert property (p_coding)
    else $error("output code ignores selected coding");
  property p_read_quiet;
    rd && !pin_load && !pin_clear |=>
      $stable(dac_reg) && $stable(ctrl) && $stable(clear_value);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read access changed register state");
  property p_clear_write;
    wr && addr == `ADDR_CLEAR_VALUE |=> clear_value == $past(data);
  endproperty
  a_clear_write: assert property (p_clear_write)
    else $error("clear value write not stored");
endmodule : dac_output_state_control
`default_nettype wire

// *** tb/host_serial_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// host serial controller model
// ---------------------------------------------------------------
module host_serial_model (
  output logic sclk, // link clock, still outside frames except in idle_clocks
  output logic sync_n, // frame select, active low
  output logic sdin, // serial data to device
  input wire logic sdo // readback from device
);
  // idle levels
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // a few link edges with no frame, only while in reset
  task automatic idle_clocks();
    repeat (4) begin
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask : idle_clocks
  // one 24-bit frame, msb first, readback caught on falling edges
  task automatic xfer(input logic rd, input logic [2:0] addr,
    input logic [19:0] data, output logic [23:0] rb);
    logic [23:0] w;
    w = {rd, addr, data};
    #1.7 sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = w[i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
      rb[i] = sdo;
    end
    #3 sync_n = 1'b1;
    sdin = ~sdin; // released line shows no stale bit
  endtask : xfer
endmodule : host_serial_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctrl_params.svh"
module tb;
  logic core_clk, rstn, ld_n, cl_n, sclk, sync_n, sdin, sdo;
  logic ref_disconnect, output_clamp, feedback_resistor_select;
  logic [19:0] dac_code;
  logic [3:0] lin_comp;
  dac_ctrl_pkg::out_state_t out_state;
  logic [31:0] outv, seed, d;
  logic [19:0] m_ctrl, m_clr, m_in, m_dac; // reference model
  logic [23:0] rb;
  int n_mismatch, n_tests;
  // ---------------------------------------------------------------
  // clock and instances
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  dac_output_state_control i_dut (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin), .sdo(sdo), .load_strobe_n(ld_n),
    .clear_strobe_n(cl_n), .dac_code(dac_code),
    .ref_disconnect(ref_disconnect), .output_clamp(output_clamp),
    .out_state(out_state), .lin_comp(lin_comp),
    .feedback_resistor_select(feedback_resistor_select)
  );
  host_serial_model i_host (
    .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo)
  );
  assign outv = {3'h0, dac_code, ref_disconnect, output_clamp, out_state,
    lin_comp, feedback_resistor_select};
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // outputs expected from the model
  function automatic logic [31:0] expv();
    logic [1:0] st;
    st = m_ctrl[`CTRL_CLAMP_BIT] ? 2'h2 : {1'h0, m_ctrl[`CTRL_FLOAT_BIT]};
    return {3'h0, m_dac ^ {m_ctrl[`CTRL_TWOS_BIT], 19'h0}, m_ctrl[3:2], st,
      m_ctrl[9:6], m_ctrl[1]};
  endfunction : expv
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (8) @(negedge core_clk);
    chk(outv, expv());
  endtask : settle
  // software strobes in the model
  task automatic sw(input logic [2:0] s);
    if (s[2]) begin
      m_ctrl = `CTRL_RST;
      m_clr = 20'h0;
      m_in = 20'h0;
      m_dac = 20'h0;
    end else if (s[1] && ld_n) begin
      m_dac = m_clr;
    end else if (s[0] && cl_n) begin
      m_dac = m_in;
    end
  endtask : sw
  task automatic wr(input logic [2:0] a, input logic [19:0] v);
    i_host.xfer(1'b0, a, v, rb);
    case (a)
      3'h1: m_in = v;
      3'h2: m_ctrl = v;
      3'h3: m_clr = v;
      3'h4: sw(v[2:0]);
      default: ;
    endcase
    settle();
  endtask : wr
  // read request, then a no-op frame carrying the answer
  task automatic rd(input logic [2:0] a, input logic [19:0] v);
    i_host.xfer(1'b1, a, 20'h0, rb);
    settle();
    i_host.xfer(1'b0, 3'h0, 20'h0, rb);
    chk({8'h0, rb}, {8'h0, 1'b1, a, v});
    settle();
  endtask : rd
  task automatic pins(input logic l, input logic c);
    @(negedge core_clk);
    if (!c && cl_n) m_dac = m_clr;
    else if (!l && ld_n) m_dac = m_in;
    ld_n = l;
    cl_n = c;
    settle();
  endtask : pins
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h0000C55E;
    rstn = 1'b0;
    ld_n = 1'b1;
    cl_n = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    sw(3'h4);
    i_host.idle_clocks();
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    settle();
    rd(3'h3, 20'h00000);
    d = rnd();
    wr(3'h1, d[19:0]);
    wr(3'h4, 20'h00001);
    wr(3'h2, 20'h00000);
    // all output states, both trim settings, both feedback settings
    for (int i = 0; i < 4; i++) begin
      d[19:0] = {10'h000, i[0] ? 4'hC : 4'h0, 2'h0, i[1:0], i[1], 1'h0};
      wr(3'h2, d[19:0]);
    end
    wr(3'h2, 20'h00000);
    d = rnd();
    wr(3'h3, d[19:0]);
    rd(3'h3, m_clr);
    wr(3'h4, 20'h00002);
    wr(3'h2, 20'h00010);
    rd(3'h2, m_ctrl);
    rd(3'h1, m_dac);
    d = rnd();
    wr(3'h1, d[19:0]);
    pins(1'b0, 1'b1);
    wr(3'h4, 20'h00002);
    pins(1'b1, 1'b1);
    d = rnd();
    wr(3'h1, d[19:0]);
    pins(1'b1, 1'b0);
    wr(3'h4, 20'h00001);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b1);
    d = rnd();
    wr(3'h4, {d[19:3], 3'h0});
    rd(3'h4, 20'h00000);
    for (int i = 5; i < 8; i++) begin
      wr(i[2:0], 20'hFFFFF);
    end
    wr(3'h4, 20'h00003);
    wr(3'h4, 20'h00004);
    rd(3'h3, 20'h00000);
    // hard reset in mid-run over a non-default control word
    wr(3'h2, 20'h00010);
    rstn = 1'b0;
    sw(3'h4);
    i_host.idle_clocks();
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    settle();
    rd(3'h2, `CTRL_RST);
    stop_test();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
